// ===== hw/bass_pkg.sv
/*
  Constants shared by the servo brake and fault sequencer: register map, field
  positions, reset values and timing counts.
  Assumes a 200 MHz system clock and a classic Wishbone register bus.
*/
package bass_pkg;
  // System clock rate and the 10ms timebase.
  localparam int unsigned CLK_HZ        = 200000000;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  // Register word addresses (byte addresses, aligned words).
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_DELAY     = 8'h04;
  localparam logic [7:0] ADDR_SPEED     = 8'h08;
  localparam logic [7:0] ADDR_WAIT      = 8'h0C;
  localparam logic [7:0] ADDR_MAXSPD    = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_OUTSEL    = 8'h18;
  // Control register fields.
  localparam int unsigned CTRL_MAP_LSB  = 0;
  localparam int unsigned CTRL_CLR_BIT  = 4;
  localparam logic [3:0]  MAP_IGNORE    = 4'h7;
  // Output select register: brake route field at bits 9:8.
  localparam int unsigned ROUTE_LSB     = 8;
  // Reset values and upper limits of the settings.
  localparam logic [15:0] OUTSEL_RST    = 16'h0000;
  localparam logic [7:0]  DELAY_RST     = 8'h00;
  localparam logic [7:0]  DELAY_MAX     = 8'h32;
  localparam logic [15:0] SPEED_RST     = 16'h0064;
  localparam logic [15:0] SPEED_MAX     = 16'h2710;
  localparam logic [7:0]  WAIT_RST      = 8'h32;
  localparam logic [7:0]  WAIT_MAX      = 8'h64;
  localparam logic [15:0] MAXSPD_RST    = 16'h1770;
  // Fault code reported for a following error and while no alarm is held: all three pins low.
  localparam logic [2:0]  CODE_NONE     = 3'h0;
  // Sequencer states.
  typedef enum logic [2:0] {BASS_OFF, BASS_ON, BASS_STOP_DLY, BASS_MOVE_WAIT} bass_state_t;
endpackage : bass_pkg

// ===== hw/bass_tick.sv
/*
  Free-running 10ms tick generator.
  Assumes one synchronous clock and a clock enable that freezes the count.
*/
`timescale 1ns/1ps
`default_nettype none
module bass_tick
  import bass_pkg::*;
#(
  parameter int unsigned PERIOD = TICK_CYCLES  // Cycles per tick.
) (
  input  wire logic clk_sys,  // System clock.
  input  wire logic reset,    // Synchronous reset, active high.
  input  wire logic ce,       // Clock enable.
  output logic      tick      // One-cycle pulse every period.
);
  logic [31:0] count;  // Cycles since the last tick.

  // Count up and wrap, pulsing in the cycle after the last count of each period.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (ce) begin
      tick  <= (count == 32'(PERIOD - 1));
      count <= (count == 32'(PERIOD - 1)) ? 32'h0 : count + 32'h1;
    end
  end
endmodule : bass_tick
`default_nettype wire

// ===== hw/bass_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module bass_sync #(
  parameter int unsigned W = 1  // Number of bits.
) (
  input  wire logic         clk_sys,  // System clock.
  input  wire logic         reset,    // Synchronous reset, active high.
  input  wire logic         ce,       // Clock enable.
  input  wire logic [W-1:0] d_in,     // Asynchronous inputs.
  input  wire logic [W-1:0] rst_val,  // Value shown during reset.
  output logic      [W-1:0] q_out     // Synchronised outputs.
);
  logic [W-1:0] stage1;  // First flop, read only by the second.

  // Two flops in series; only the second is visible.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1 <= rst_val;
      q_out  <= rst_val;
    end else if (ce) begin
      stage1 <= d_in;
      q_out  <= stage1;
    end
  end
endmodule : bass_sync
`default_nettype wire

// ===== hw/bass_seq.sv
/*
  Brake, servo-enable and fault sequencer of a servo amplifier, with a classic
  Wishbone register slave.
  Assumes speed and alarm inputs come from logic on clk_sys, while the enable
  and fault-clear pins are asynchronous and pass through a synchroniser.

  // What this block does
  // - Brake release output low releases, high applies.
  // - Two-bit route field picks one of three outputs.
  // - Shared output circuits carry OR of signals.
  // - Stopped servo off: brake first, delayed motor off.
  // - Zero delay switches motor off with brake.
  // - Stop delay only when stopped; motion uses threshold.
  // - Alarm switches motor off at once.
  // - Speed threshold setting 0 to 10000, default 100.
  // - Wait time setting 0 to 100 ticks, default 50.
  // - Brake applies on low speed or wait expiry.
  // - Threshold above maximum speed uses maximum speed.
  // - Fault output low normally, high on alarm.
  // - Three open-collector lines give fault type.
  // - Fault clear input high clears latched alarm.
  // - Power cycle clears every latched alarm.
  // - Encoder alarms survive fault clear until power cycle.
  // - Panel clear request acts like fault clear.
  // - Following errors never shown on fault code.
  // - Enable low runs motor, high stops it.
  // - Servo off on enable loss, alarm or power.
  // - Enable map value seven forces servo on.
*/
`timescale 1ns/1ps
`default_nettype none
module bass_seq
  import bass_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES  // Cycles per 10ms tick.
) (
  input  wire logic        clk_sys,          // System clock, 200 MHz.
  input  wire logic        reset,            // Synchronous reset, control power up.
  input  wire logic        ce,               // Clock enable, freezes all state when low.
  input  wire logic        wb_cyc_i,         // Wishbone cycle.
  input  wire logic        wb_stb_i,         // Wishbone strobe.
  input  wire logic        wb_we_i,          // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,         // Wishbone byte address.
  input  wire logic [31:0] wb_dat_i,         // Wishbone write data.
  input  wire logic [3:0]  wb_sel_i,         // Wishbone byte selects.
  output logic      [31:0] wb_dat_o,         // Wishbone read data.
  output logic             wb_ack_o,         // Wishbone acknowledge.
  input  wire logic        drive_enable_n,   // Drive-enable pin, low is active.
  input  wire logic        fault_clear_in,   // Fault-clear pin, high is ON.
  input  wire logic        panel_clear,      // Panel operator clear pulse, same clock.
  input  wire logic [15:0] motor_speed,      // Measured speed magnitude, rpm.
  input  wire logic        alarm_event,      // Alarm detected pulse, same clock.
  input  wire logic [2:0]  alarm_code,       // Alarm type with the event.
  input  wire logic        alarm_encoder,    // Alarm is encoder related.
  input  wire logic        alarm_following,  // Alarm is a following error.
  input  wire logic [2:0]  other_out_sig,    // Other status signals per circuit.
  output logic             motor_on,         // Motor power stage energised.
  output logic             brake_release_out,// Brake release, low releases.
  output logic [2:0]       out_circuit_n,    // Output circuits, low is closed.
  output logic             servo_fault_out,  // Fault output, high on alarm.
  output logic             fault_code_bit_a, // Fault code bit 0, open-collector.
  output logic             fault_code_bit_b, // Fault code bit 1, open-collector.
  output logic             fault_code_bit_c  // Fault code bit 2, open-collector.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and timebase.

  logic [1:0] pins_sync;  // Synchronised enable (bit 0) and clear (bit 1).
  logic       tick;       // 10ms pulse.

  bass_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ce      (ce),
    .d_in    ({fault_clear_in, drive_enable_n}),
    .rst_val (2'b01),
    .q_out   (pins_sync)
  );

  bass_tick #(.PERIOD(TICK_PERIOD)) u_tick (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ce      (ce),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [3:0]  enable_input_map;       // Enable pin mapping field.
  logic [15:0] output_select_two;      // Output selection register.
  logic [7:0]  brake_to_off_delay;     // Stopped delay, 10ms units.
  logic [15:0] brake_speed_threshold;  // Moving speed threshold, rpm.
  logic [7:0]  brake_wait_time;        // Moving wait time, 10ms units.
  logic [15:0] max_speed;              // Motor maximum speed, rpm.
  logic        sw_clear;               // Software clear pulse.

  wire        wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;  // New request.
  wire        wb_wr      = wb_req & wb_we_i & wb_sel_i[0];   // Write of low lane.
  wire        wb_wr_hi   = wb_req & wb_we_i & wb_sel_i[1];   // Write of second lane.
  wire [15:0] wr_half    = wb_dat_i[15:0];                   // Written halfword.
  wire [1:0]  brake_output_route = output_select_two[ROUTE_LSB +: 2];  // Brake route.

  // Settings are clamped to their documented ranges as they are written.
  wire [7:0]  delay_wr   = (wb_dat_i[7:0] > DELAY_MAX) ? DELAY_MAX : wb_dat_i[7:0];
  wire [15:0] speed_wr   = (wr_half > SPEED_MAX) ? SPEED_MAX : wr_half;
  wire [7:0]  wait_wr    = (wb_dat_i[7:0] > WAIT_MAX) ? WAIT_MAX : wb_dat_i[7:0];

  // Register writes; lanes above the fields are ignored.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enable_input_map      <= 4'h0;
      output_select_two     <= OUTSEL_RST;
      brake_to_off_delay    <= DELAY_RST;
      brake_speed_threshold <= SPEED_RST;
      brake_wait_time       <= WAIT_RST;
      max_speed             <= MAXSPD_RST;
      sw_clear              <= 1'b0;
    end else if (ce) begin
      sw_clear <= wb_wr & (wb_adr_i == ADDR_CTRL) & wb_dat_i[CTRL_CLR_BIT];
      if (wb_wr) begin
        case (wb_adr_i)
          ADDR_CTRL:   enable_input_map   <= wb_dat_i[CTRL_MAP_LSB +: 4];
          ADDR_DELAY:  brake_to_off_delay <= delay_wr;
          ADDR_SPEED:  brake_speed_threshold[7:0] <= speed_wr[7:0];
          ADDR_WAIT:   brake_wait_time    <= wait_wr;
          ADDR_MAXSPD: max_speed[7:0]     <= wr_half[7:0];
          ADDR_OUTSEL: output_select_two[7:0] <= wr_half[7:0];
          default: ;
        endcase
      end
      if (wb_wr_hi) begin
        case (wb_adr_i)
          ADDR_SPEED:  brake_speed_threshold[15:8] <= speed_wr[15:8];
          ADDR_MAXSPD: max_speed[15:8]     <= wr_half[15:8];
          ADDR_OUTSEL: output_select_two[15:8] <= wr_half[15:8];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm latch.

  logic       alarm_latched;  // Any alarm held.
  logic       alarm_enc;      // Held alarm is encoder related.
  logic [2:0] code_latched;   // Held fault code.

  wire clear_req  = pins_sync[1] | panel_clear | sw_clear;
  wire clear_ok   = clear_req & ~alarm_enc;
  // A following error is still an alarm but reports no code.
  wire [2:0] code_in = alarm_following ? CODE_NONE : alarm_code;

  // A new alarm wins over a clear in the same cycle; reset is power-up.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alarm_latched <= 1'b0;
      alarm_enc     <= 1'b0;
      code_latched  <= CODE_NONE;
    end else if (ce) begin
      if (alarm_event) begin
        alarm_latched <= 1'b1;
        alarm_enc     <= alarm_enc | alarm_encoder;
        code_latched  <= code_in;
      end else if (clear_ok) begin
        alarm_latched <= 1'b0;
        code_latched  <= CODE_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Servo on/off sequencer.

  bass_state_t state;        // Sequencer state.
  bass_state_t next_state;   // Next sequencer state.
  logic [7:0]  tick_count;   // Ticks since servo off.
  logic        motor_reg;    // Motor output register.
  logic        brake_apply;  // Brake applied (release output high).

  // The map value seven ignores the pin and keeps the servo commanded on.
  wire enable_cmd = (enable_input_map == MAP_IGNORE) | ~pins_sync[0];
  wire alarm_any  = alarm_latched | alarm_event;
  wire servo_req  = enable_cmd & ~alarm_any;
  // A threshold above the motor maximum behaves as the maximum.
  wire [15:0] eff_thresh = (brake_speed_threshold > max_speed) ? max_speed
                                                               : brake_speed_threshold;
  wire stopped    = (motor_speed == 16'h0000);
  wire slow       = (motor_speed < eff_thresh);
  wire delay_done = tick_count >= brake_to_off_delay;
  wire wait_done  = tick_count >= brake_wait_time;

  // Next-state choice; alarms always drop the motor without waiting.
  always_comb begin
    next_state = state;
    case (state)
      BASS_OFF: begin
        if (servo_req) next_state = BASS_ON;
      end
      BASS_ON: begin
        if (!servo_req) begin
          if (stopped && !alarm_any) begin
            next_state = (brake_to_off_delay == 8'h00) ? BASS_OFF : BASS_STOP_DLY;
          end else if (stopped) begin
            next_state = BASS_OFF;
          end else begin
            next_state = BASS_MOVE_WAIT;
          end
        end
      end
      BASS_STOP_DLY: begin
        if (alarm_any || delay_done) next_state = BASS_OFF;
      end
      BASS_MOVE_WAIT: begin
        if (slow || wait_done) next_state = BASS_OFF;
      end
      default: next_state = BASS_OFF;
    endcase
  end

  // State, tick counter and outputs; the counter restarts at servo off.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state       <= BASS_OFF;
      tick_count  <= 8'h00;
      motor_reg   <= 1'b0;
      brake_apply <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      if (state == BASS_ON) tick_count <= 8'h00;
      else if (tick && tick_count != 8'hFF) tick_count <= tick_count + 8'h01;
      // Brake is applied on any exit from ON except motion wait.
      brake_apply <= (next_state != BASS_ON) && (next_state != BASS_MOVE_WAIT);
      // Any alarm drops the motor at once, even while the brake waits for speed.
      motor_reg   <= (next_state != BASS_OFF) && !alarm_any;
    end
  end

  // The alarm cuts the motor in the same cycle it is seen.
  assign motor_on = motor_reg & ~alarm_event;

  ////////////////////////////////////////////////////////////////////////////
  // Output pins.

  logic [2:0] circuit_reg;  // Active-high content of each output circuit.

  // Each output circuit ORs the brake release with other allocated signals.
  generate
    for (genvar i = 0; i < 3; i++) begin : g_circ
      wire brk_here = (brake_output_route == 2'(i + 1)) & ~brake_apply;
      always_ff @(posedge clk_sys) begin
        if (reset) circuit_reg[i] <= 1'b0;
        else if (ce) circuit_reg[i] <= brk_here | other_out_sig[i];
      end
    end
  endgenerate

  assign out_circuit_n     = ~circuit_reg;
  assign brake_release_out = brake_apply;
  assign servo_fault_out   = alarm_latched;
  assign fault_code_bit_a  = code_latched[0];
  assign fault_code_bit_b  = code_latched[1];
  assign fault_code_bit_c  = code_latched[2];

  ////////////////////////////////////////////////////////////////////////////
  // Register read path and acknowledge.

  wire [31:0] status_word = {24'h0, 1'b0, state, alarm_enc, alarm_latched, brake_apply,
                             motor_reg};
  wire [31:0] rd_mux = (wb_adr_i == ADDR_CTRL)   ? {28'h0, enable_input_map} :
                       (wb_adr_i == ADDR_DELAY)  ? {24'h0, brake_to_off_delay} :
                       (wb_adr_i == ADDR_SPEED)  ? {16'h0, brake_speed_threshold} :
                       (wb_adr_i == ADDR_WAIT)   ? {24'h0, brake_wait_time} :
                       (wb_adr_i == ADDR_MAXSPD) ? {16'h0, max_speed} :
                       (wb_adr_i == ADDR_STATUS) ? status_word :
                       (wb_adr_i == ADDR_OUTSEL) ? {16'h0, output_select_two} : 32'h0;

  // One wait state: ack one cycle after the strobe, dropped the next cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      if (wb_req) wb_dat_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_alarm_cuts_motor: assert property (@(posedge clk_sys) disable iff (reset)
    ce && alarm_event |-> !motor_on ##1 (!ce || !motor_on))
    else $error("Motor stayed on after an alarm.");

  a_fault_follows_alarm: assert property (@(posedge clk_sys) disable iff (reset)
    ce && alarm_event |=> servo_fault_out)
    else $error("Fault output not raised after an alarm.");

  a_clear_drops_fault: assert property (@(posedge clk_sys) disable iff (reset)
    ce && clear_req && !alarm_enc && !alarm_event |=> !servo_fault_out)
    else $error("Fault clear did not drop the fault output.");

  a_encoder_holds: assert property (@(posedge clk_sys) disable iff (reset)
    ce && alarm_enc && servo_fault_out && !alarm_event |=> servo_fault_out)
    else $error("Encoder alarm was cleared without a power cycle.");

  a_no_follow_code: assert property (@(posedge clk_sys) disable iff (reset)
    ce && alarm_event && alarm_following |=> {fault_code_bit_c, fault_code_bit_b,
                                             fault_code_bit_a} == CODE_NONE)
    else $error("Following error reported a fault code.");

  a_motor_needs_brake: assert property (@(posedge clk_sys) disable iff (reset)
    state == BASS_STOP_DLY |-> brake_release_out && motor_reg)
    else $error("Stop delay without brake applied or motor on.");

  a_zero_delay_same: assert property (@(posedge clk_sys) disable iff (reset)
    ce && $rose(brake_release_out) && $past(state) == BASS_ON && brake_to_off_delay == 8'h00
    && !$past(alarm_any) |-> !motor_reg)
    else $error("Motor still on with zero brake delay.");

  a_map_ignores_pin: assert property (@(posedge clk_sys) disable iff (reset)
    ce && enable_input_map == MAP_IGNORE && !alarm_any && state == BASS_OFF |=>
    motor_reg && !brake_release_out)
    else $error("Ignored enable pin did not turn the servo on.");

  a_fault_stops_motor: assert property (@(posedge clk_sys) disable iff (reset)
    servo_fault_out |-> !motor_on)
    else $error("Motor on while an alarm is latched.");

  a_move_holds_release: assert property (@(posedge clk_sys) disable iff (reset)
    state == BASS_MOVE_WAIT |-> !brake_release_out)
    else $error("Brake applied before the motion condition was met.");

  a_release_when_on: assert property (@(posedge clk_sys) disable iff (reset)
    ce && state == BASS_ON && next_state == BASS_ON |=> !brake_release_out)
    else $error("Brake applied while servo on.");
endmodule : bass_seq
`default_nettype wire

// ===== sim/bass_host.sv
/*
  Host controller model that drives the enable and fault-clear pins.
  Assumes the bench commands it on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bass_host (
  input  wire logic clk_sys,        // System clock.
  input  wire logic servo_cmd,      // Bench wants the servo on.
  input  wire logic clear_cmd,      // Bench wants the fault cleared.
  input  wire logic fault,          // Fault output of the drive.
  output var  logic drive_enable_n, // Enable pin, low runs the motor.
  output var  logic fault_clear_in  // Clear pin, high clears.
);
  //////////////////////////////////////////////////////////////////////////
  // Pins start released, so nothing runs before the bench asks.
  initial begin
    drive_enable_n = 1'b1;
    fault_clear_in = 1'b0;
  end
  // A fault drops the enable, so an alarm never restarts the motor alone.
  always @(posedge clk_sys) begin
    drive_enable_n <= !(servo_cmd && !fault);
    fault_clear_in <= clear_cmd;
  end
endmodule : bass_host
`default_nettype wire

// ===== sim/bass_seq_test.sv
/*
  Self-checking bench for the brake and fault sequencer.
  Assumes the host model on the pins and a short tick period.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module bass_seq_test;
  import bass_pkg::*;
  localparam int unsigned TP = 10;  // Short tick keeps the run brief.
  logic        clk_sys, reset, cyc, stb, we, ack, servo_cmd, clear_cmd;
  logic        den_n, fclr, panel_clear, alarm_event, alarm_encoder;
  logic        alarm_following, motor_on, brake, fault, ca, cb, cc;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [15:0] speed;
  logic [2:0]  code, other, circ;
  int          failures, tests_run, cycles;
  //////////////////////////////////////////////////////////////////////////
  bass_seq #(.TICK_PERIOD(TP)) bass_seq_i (.clk_sys(clk_sys), .reset(reset),
    .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
    .drive_enable_n(den_n), .fault_clear_in(fclr), .panel_clear(panel_clear),
    .motor_speed(speed), .alarm_event(alarm_event), .alarm_code(code),
    .alarm_encoder(alarm_encoder), .alarm_following(alarm_following),
    .other_out_sig(other), .motor_on(motor_on), .brake_release_out(brake),
    .out_circuit_n(circ), .servo_fault_out(fault), .fault_code_bit_a(ca),
    .fault_code_bit_b(cb), .fault_code_bit_c(cc));
  bass_host bass_host_i (.clk_sys(clk_sys), .servo_cmd(servo_cmd),
    .clear_cmd(clear_cmd), .fault(fault), .drive_enable_n(den_n),
    .fault_clear_in(fclr));
  //////////////////////////////////////////////////////////////////////////
  // Reads after an edge see the settled values of the cycle before it.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  // Classic single cycle; waits for ack with no assumed latency.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Bounded wait for the brake output to reach a level.
  task automatic await_brake(input logic v, input int lim);
    for (int k = 0; k < lim && brake !== v; k++) step(1);
    `CHK(brake, v)
  endtask : await_brake
  task automatic servo_on();
    servo_cmd <= 1'b1;
    step(8);
    `CHK(motor_on, 1'b1)
    `CHK(brake, 1'b0)
  endtask : servo_on
  // One-cycle alarm pulse; motor must be off in that very cycle.
  task automatic raise(input logic [2:0] c, input logic enc, input logic fol);
    alarm_event <= 1'b1;
    code <= c;
    alarm_encoder <= enc;
    alarm_following <= fol;
    step(1);
    `CHK(motor_on, 1'b0)
    alarm_event <= 1'b0;
    step(1);
    `CHK(fault, 1'b1)
  endtask : raise
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(0, ADDR_DELAY, 32'h0);
    `CHK(q, {24'h0, DELAY_RST})
    wb(0, ADDR_WAIT, 32'h0);
    `CHK(q, {24'h0, WAIT_RST})
    wb(0, ADDR_OUTSEL, 32'h0);
    `CHK(q, {16'h0, OUTSEL_RST})
    wb(0, ADDR_SPEED, 32'h0);
    `CHK(q, {16'h0, SPEED_RST})
    wb(1, ADDR_SPEED, 32'h0000_3000);
    wb(0, ADDR_SPEED, 32'h0);
    `CHK(q, {16'h0, SPEED_MAX})
    wb(0, 8'hFC, 32'h0);
    `CHK(q, 32'h0)
    $display("test regs done");
  endtask : t_regs
  // Stopped servo off: brake first, motor after d ticks.
  task automatic t_stop(input logic [7:0] d);
    wb(1, ADDR_DELAY, {24'h0, d});
    servo_on();
    `CHK(circ, 3'b111)
    servo_cmd <= 1'b0;
    await_brake(1'b1, 10);
    `CHK(motor_on, (d != 8'h00))
    if (d != 8'h00) begin
      step(TP * (int'(d) - 1) - 1);
      `CHK(motor_on, 1'b1)
      step(2 * TP + 2);
      `CHK(motor_on, 1'b0)
    end
    wb(1, ADDR_DELAY, 32'h0);
    $display("test stop done");
  endtask : t_stop
  // Brake route field 2 puts the brake on the middle circuit.
  task automatic t_route();
    wb(1, ADDR_OUTSEL, 32'h0000_0200);
    step(2);
    `CHK(circ, 3'b111)
    servo_on();
    `CHK(circ, 3'b101)
    other <= 3'b011;
    step(2);
    `CHK(circ, 3'b100)
    servo_cmd <= 1'b0;
    await_brake(1'b1, 10);
    `CHK(circ, 3'b100)
    other <= 3'b000;
    step(2);
    `CHK(circ, 3'b111)
    $display("test route done");
  endtask : t_route
  // Servo off in motion: threshold clipped to max speed, then wait time.
  task automatic t_move();
    wb(1, ADDR_MAXSPD, 32'h0000_0100);
    wb(1, ADDR_SPEED, 32'h0000_03E8);
    wb(1, ADDR_WAIT, 32'h0000_0005);
    speed <= 16'h012C;
    servo_on();
    servo_cmd <= 1'b0;
    step(12);
    `CHK(brake, 1'b0)
    speed <= 16'h00C8;
    await_brake(1'b1, 4);
    `CHK(motor_on, 1'b0)
    speed <= 16'h012C;
    servo_on();
    servo_cmd <= 1'b0;
    step(30);
    `CHK(brake, 1'b0)
    await_brake(1'b1, 40);
    speed <= 16'h0000;
    $display("test move done");
  endtask : t_move
  task automatic t_map();
    wb(1, ADDR_CTRL, 32'h0000_0007);
    step(8);
    `CHK(motor_on, 1'b1)
    wb(1, ADDR_CTRL, 32'h0);
    await_brake(1'b1, 10);
    $display("test map done");
  endtask : t_map
  task automatic t_alarm();
    servo_on();
    raise(3'h5, 1'b0, 1'b0);
    `CHK({cc, cb, ca}, 3'h5)
    clear_cmd <= 1'b1;
    step(6);
    `CHK(fault, 1'b0)
    clear_cmd <= 1'b0;
    step(4);
    raise(3'h3, 1'b0, 1'b0);
    panel_clear <= 1'b1;
    step(1);
    panel_clear <= 1'b0;
    step(3);
    `CHK(fault, 1'b0)
    raise(3'h1, 1'b0, 1'b0);
    wb(1, ADDR_CTRL, 32'h0000_0010);
    step(1);
    `CHK(fault, 1'b0)
    raise(3'h6, 1'b0, 1'b1);
    `CHK({cc, cb, ca}, CODE_NONE)
    raise(3'h2, 1'b1, 1'b0);
    clear_cmd <= 1'b1;
    step(6);
    `CHK(fault, 1'b1)
    clear_cmd <= 1'b0;
    reset <= 1'b1;
    step(5);
    reset <= 1'b0;
    step(1);
    `CHK(fault, 1'b0)
    $display("test alarm done");
  endtask : t_alarm
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = !clk_sys;
  end
  // A hang counts as a mismatch and still reaches the closing report.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    {reset, cyc, stb, we, servo_cmd, clear_cmd, panel_clear} = 7'h40;
    {alarm_event, alarm_encoder, alarm_following} = 3'h0;
    {adr, wdat, speed, code, other} = 62'h0;
    {failures, tests_run, cycles} = '0;
    step(5);
    reset <= 1'b0;
    step(1);
    `CHK(brake, 1'b1)
    `CHK(fault, 1'b0)
    t_regs();
    t_stop(8'h00);
    t_stop(8'h02);
    t_route();
    t_move();
    t_map();
    t_alarm();
    conclude();
  end
endmodule : bass_seq_test
`default_nettype wire
